// [rtl/msc_defines.svh]
// Purpose: Constants of the serial channel slave port
// Assumes: Core clock of 200 MHz
// Notes:   Definitions only
`ifndef MSC_DEFINES_SVH
`define MSC_DEFINES_SVH

// ==========================================================
// Downstream frame layout (bit counts include selection bit)
`define MSC_CMD_LEN        6'd15
`define MSC_DAT_LEN        6'd31
`define MSC_CODE_LSB       17
`define MSC_ARG_LSB        23
`define MSC_W1_LSB         1
`define MSC_W2_LSB         9
`define MSC_W3_LSB         17
`define MSC_W4_LSB         25

// ==========================================================
// Command codes
`define MSC_CMD_SET_DIV    6'h01
`define MSC_CMD_READ_BIT   5

// ==========================================================
// Upstream framing and divider
`define MSC_DIV_RST        2'h2
`define MSC_DIV_BASE       8'h10
`define MSC_FRAME_BITS     5'h10

// ==========================================================
// Timing
`define MSC_CLK_NS         5
`define MSC_LINK_MIN_NS    25
`define MSC_EXEC_LINK_CYC  16
`define MSC_READ_LIMIT_NS  100000

`endif

// [rtl/msc_pkg.sv]
// Purpose: Types of the serial channel slave port
// Assumes: Nothing
// Notes:   Constants live in msc_defines.svh
package msc_pkg;

  // ========================================================
  // Types
  typedef logic [5:0] msc_code_t;
  typedef logic [7:0] msc_byte_t;
  typedef logic [3:0] msc_addr_t;

  typedef enum logic [1:0] {
    MSC_SQ_IDLE = 2'b00,
    MSC_SQ_BUSY = 2'b01
  } msc_seq_t;

endpackage

// [rtl/msc_buf2.sv]
// Purpose: Two-entry valid/ready buffer
// Assumes: Single clock
// Notes:   Full and empty are exact
`timescale 1ns/1ps
module msc_buf2 #(
  parameter int W = 14
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem_q [2];
  logic [W-1:0] mem_d [2];
  logic         wp_q, wp_d, rp_q, rp_d;
  logic [1:0]   cnt_q, cnt_d;
  logic         push, pop;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    mem_d = mem_q;
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = in_data;
      wp_d        = ~wp_q;
    end
    if (pop) begin
      rp_d = ~rp_q;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      mem_q <= mem_d;
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // ========================================================
  // Checks
  AST_BUF_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    (out_valid && !out_ready) |=> (out_valid && $stable(out_data)))
    else $error("buffer head lost while stalled");

endmodule // msc_buf2

// [rtl/msc_up_tx.sv]
// Purpose: Upstream frame serializer with bit-rate divider
// Assumes: link_tick is one pulse per link clock period
// Notes:   Sixteen frame bits, then one released inter-frame bit
`timescale 1ns/1ps
`include "msc_defines.svh"
module msc_up_tx (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             link_tick,
  input  wire logic [1:0]       div_sel,
  input  wire logic             start,
  input  wire msc_pkg::msc_addr_t addr,
  input  wire msc_pkg::msc_byte_t data,
  output logic                  up_out,
  output logic                  up_oe,
  output logic                  busy,
  output logic                  done
);
  import msc_pkg::*;

  logic [15:0] sh_q, sh_d;
  logic [4:0]  bit_q, bit_d;
  logic [6:0]  tcnt_q, tcnt_d, lim;
  logic        busy_q, busy_d, oe_q, oe_d, out_q, out_d, done_q, done_d;

  assign lim    = 7'((`MSC_DIV_BASE << div_sel) - 8'h01);
  assign up_out = out_q;
  assign up_oe  = oe_q;
  assign busy   = busy_q;
  assign done   = done_q;

  always_comb begin
    sh_d   = sh_q;
    bit_d  = bit_q;
    tcnt_d = tcnt_q;
    busy_d = busy_q;
    oe_d   = oe_q;
    out_d  = out_q;
    done_d = 1'b0;
    if (start) begin
      // Stop, stop, odd parity, data, address, start
      sh_d   = {2'b11, ~^{data, addr}, data, addr, 1'b0};
      bit_d  = 5'h00;
      tcnt_d = 7'h00;
      busy_d = 1'b1;
      oe_d   = 1'b1;
      out_d  = 1'b0;
    end else if (busy_q && link_tick) begin
      if (tcnt_q == lim) begin
        tcnt_d = 7'h00;
        bit_d  = bit_q + 5'h01;
        if (bit_q == `MSC_FRAME_BITS) begin
          busy_d = 1'b0;
          done_d = 1'b1;
        end else if (bit_q == 5'(`MSC_FRAME_BITS - 5'h01)) begin
          oe_d  = 1'b0;
          out_d = 1'b1;
        end else begin
          sh_d  = {1'b1, sh_q[15:1]};
          out_d = sh_q[1];
        end
      end else begin
        tcnt_d = tcnt_q + 7'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sh_q   <= 16'hFFFF;
      bit_q  <= 5'h00;
      tcnt_q <= 7'h00;
      busy_q <= 1'b0;
      oe_q   <= 1'b0;
      out_q  <= 1'b1;
      done_q <= 1'b0;
    end else begin
      sh_q   <= sh_d;
      bit_q  <= bit_d;
      tcnt_q <= tcnt_d;
      busy_q <= busy_d;
      oe_q   <= oe_d;
      out_q  <= out_d;
      done_q <= done_d;
    end
  end

  // ========================================================
  // Checks
  AST_TX_HIZ: assert property (@(posedge core_clk) disable iff (!rst_n)
    !busy_q |-> !oe_q)
    else $error("upstream driven outside a frame");
  AST_TX_START: assert property (@(posedge core_clk) disable iff (!rst_n)
    start |=> (oe_q && !out_q && (sh_q[15:14] == 2'b11)))
    else $error("frame does not open with start bit");
  AST_TX_PARITY: assert property (@(posedge core_clk) disable iff (!rst_n)
    start |=> (^sh_q == 1'b1))
    else $error("upstream frame parity not odd");

endmodule // msc_up_tx

// [rtl/msc_slave.sv]
// Purpose: Serial channel slave port, downstream receive and upstream send
// Assumes: Link clock and select sampled on core_clk, link at most 40 MHz
// Notes:   Read data supplied by the register side on reg_addr/reg_data
//
// How it works
// - Select is active low; frame spans select fall to select rise.
// - Host drives data on rising link edges; sampled on falling edges.
// - Downstream bits count only while select is active.
// - Data, clock and upstream are high-true; select is low-true.
// - Command frame: selection one, 6-bit code, 8-bit argument, LSB first.
// - Command with wrong bit count is dropped and flags length error.
// - Data frame: selection zero, 30 bits into four control words.
// - Data frame with wrong bit count is dropped and flags length error.
// - Frames take effect within 16 link periods after select rises.
// - Upstream bit time is link clock divided by 16..128, reset 64.
// - Upstream frame: start, 4 address, 8 data, parity, two stops.
// - Upstream parity makes the whole frame odd.
// - Each read command returns four registers in four frames.
// - Next frame follows stop bits plus one idle bit.
// - New read ends current frame, then restarts the four-frame set.
// - Starting a frame clears latched flags of the carried register.
// - First answer frame starts under 100 us after the read.
// - Upstream output released whenever no frame is being sent.
// - A rejected frame changes no output except the error flag.
`timescale 1ns/1ps
`include "msc_defines.svh"
module msc_slave #(
  parameter int READ_LIMIT_CYC = `MSC_READ_LIMIT_NS / `MSC_CLK_NS
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              link_clock_pos,
  input  wire logic              link_clock_neg,
  input  wire logic              downstream_data_pos,
  input  wire logic              downstream_data_neg,
  input  wire logic              select_n,
  output logic                   upstream_out,
  output logic                   upstream_oe,
  output logic                   cmd_valid,
  input  wire logic              cmd_ready,
  output msc_pkg::msc_code_t     cmd_code,
  output msc_pkg::msc_byte_t     cmd_arg,
  output msc_pkg::msc_byte_t     control_word_one,
  output msc_pkg::msc_byte_t     control_word_two,
  output msc_pkg::msc_byte_t     control_word_three,
  output logic [5:0]             control_word_four,
  output logic                   control_update,
  output logic                   frame_length_error_flag,
  input  wire logic              length_error_clear,
  output msc_pkg::msc_addr_t     reg_addr,
  input  wire msc_pkg::msc_byte_t reg_data,
  output logic                   reg_flags_clear
);
  import msc_pkg::*;

  localparam int EXEC_CYC =
    (`MSC_EXEC_LINK_CYC * `MSC_LINK_MIN_NS) / `MSC_CLK_NS;
  function automatic logic is_read(input msc_code_t c);
    is_read = c[`MSC_CMD_READ_BIT];
  endfunction

  // ==========================================================
  // Pin synchronisers: clock, data, select
  logic [2:0] raw, s1_q, s2_q, s3_q, filt_q, filt_d;
  assign raw = {select_n,
                downstream_data_pos & ~downstream_data_neg,
                link_clock_pos & ~link_clock_neg};
  generate
    for (genvar i = 0; i < 3; i++) begin : g_sync
      always_comb begin
        filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
      end
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          s1_q[i]   <= 1'b1;
          s2_q[i]   <= 1'b1;
          s3_q[i]   <= 1'b1;
          filt_q[i] <= 1'b1;
        end else begin
          s1_q[i]   <= raw[i];
          s2_q[i]   <= s1_q[i];
          s3_q[i]   <= s2_q[i];
          filt_q[i] <= filt_d[i];
        end
      end
    end
  endgenerate
  logic link_fall, link_rise, sel_act, sel_fall, sel_rise;
  assign link_fall = filt_q[0] & ~filt_d[0];
  assign link_rise = ~filt_q[0] & filt_d[0];
  assign sel_act   = ~filt_q[2];
  assign sel_fall  = filt_q[2] & ~filt_d[2];
  assign sel_rise  = ~filt_q[2] & filt_d[2];

  // ==========================================================
  // Downstream receiver
  logic [30:0] shift_q, shift_d;
  logic [5:0]  cnt_q, cnt_d;
  logic        first_q, first_d;
  logic        good_cmd, good_dat, bad_len;
  logic [7:0]  w1_q, w1_d, w2_q, w2_d, w3_q, w3_d;
  logic [5:0]  w4_q, w4_d;
  logic        upd_q, upd_d, lerr_q, lerr_d;
  logic        stg_q, stg_d;
  logic [13:0] stg_data_q, stg_data_d;
  logic        buf_in_ready;
  assign good_cmd = sel_rise & first_q & (cnt_q == `MSC_CMD_LEN);
  assign good_dat = sel_rise & ~first_q & (cnt_q == `MSC_DAT_LEN);
  assign bad_len  = sel_rise & ~good_cmd & ~good_dat;
  always_comb begin
    shift_d    = shift_q;
    cnt_d      = cnt_q;
    first_d    = first_q;
    w1_d       = w1_q;
    w2_d       = w2_q;
    w3_d       = w3_q;
    w4_d       = w4_q;
    upd_d      = 1'b0;
    lerr_d     = lerr_q;
    stg_d      = stg_q;
    stg_data_d = stg_data_q;
    if (sel_fall) begin
      cnt_d = 6'h00;
    end else if (link_fall && sel_act) begin
      shift_d = {filt_q[1], shift_q[30:1]};
      if (cnt_q == 6'h00) begin
        first_d = filt_q[1];
      end
      if (cnt_q != 6'h3F) begin
        cnt_d = cnt_q + 6'h01;
      end
    end
    if (good_dat) begin
      w1_d  = shift_q[`MSC_W1_LSB +: 8];
      w2_d  = shift_q[`MSC_W2_LSB +: 8];
      w3_d  = shift_q[`MSC_W3_LSB +: 8];
      w4_d  = shift_q[`MSC_W4_LSB +: 6];
      upd_d = 1'b1;
    end
    if (stg_q && buf_in_ready) begin
      stg_d = 1'b0;
    end
    if (good_cmd) begin
      stg_d      = 1'b1;
      stg_data_d = {shift_q[`MSC_ARG_LSB +: 8],
                    shift_q[`MSC_CODE_LSB +: 6]};
    end
    if (bad_len) begin
      lerr_d = 1'b1;
    end else if (length_error_clear) begin
      lerr_d = 1'b0;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      shift_q    <= 31'h0000_0000;
      cnt_q      <= 6'h00;
      first_q    <= 1'b0;
      w1_q       <= 8'h00;
      w2_q       <= 8'h00;
      w3_q       <= 8'h00;
      w4_q       <= 6'h00;
      upd_q      <= 1'b0;
      lerr_q     <= 1'b0;
      stg_q      <= 1'b0;
      stg_data_q <= 14'h0000;
    end else begin
      shift_q    <= shift_d;
      cnt_q      <= cnt_d;
      first_q    <= first_d;
      w1_q       <= w1_d;
      w2_q       <= w2_d;
      w3_q       <= w3_d;
      w4_q       <= w4_d;
      upd_q      <= upd_d;
      lerr_q     <= lerr_d;
      stg_q      <= stg_d;
      stg_data_q <= stg_data_d;
    end
  end
  assign control_word_one        = w1_q;
  assign control_word_two        = w2_q;
  assign control_word_three      = w3_q;
  assign control_word_four       = w4_q;
  assign control_update          = upd_q;
  assign frame_length_error_flag = lerr_q;

  // ==========================================================
  // Command buffer and dispatch
  logic        bo_valid, bo_ready, internal;
  logic [13:0] bo_data;
  msc_code_t   bo_code;
  msc_buf2 #(.W(14)) u_buf (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (stg_q),
    .in_ready  (buf_in_ready),
    .in_data   (stg_data_q),
    .out_valid (bo_valid),
    .out_ready (bo_ready),
    .out_data  (bo_data)
  );
  assign bo_code   = bo_data[5:0];
  assign internal  = is_read(bo_code) | (bo_code == `MSC_CMD_SET_DIV);
  assign bo_ready  = internal | cmd_ready;
  assign cmd_valid = bo_valid & ~internal;
  assign cmd_code  = bo_code;
  assign cmd_arg   = bo_data[13:6];

  // ==========================================================
  // Read sequencer
  msc_seq_t   seq_q, seq_d;
  logic [1:0] div_q, div_d, blk_q, blk_d, idx_q, idx_d;
  logic [1:0] pblk_q, pblk_d;
  logic       pend_q, pend_d, tx_start, tx_done, rd_pop;
  logic [15:0] lat_q, lat_d;
  assign rd_pop = bo_valid & is_read(bo_code);
  always_comb begin
    seq_d    = seq_q;
    div_d    = div_q;
    blk_d    = blk_q;
    idx_d    = idx_q;
    pblk_d   = pblk_q;
    pend_d   = pend_q;
    tx_start = 1'b0;
    if (bo_valid && bo_code == `MSC_CMD_SET_DIV) begin
      div_d = bo_data[7:6];
    end
    unique case (seq_q)
      MSC_SQ_IDLE: begin
        if (pend_q) begin
          tx_start = 1'b1;
          blk_d    = pblk_q;
          idx_d    = 2'h0;
          pend_d   = 1'b0;
          seq_d    = MSC_SQ_BUSY;
        end
      end
      MSC_SQ_BUSY: begin
        if (tx_done) begin
          if (pend_q) begin
            tx_start = 1'b1;
            blk_d    = pblk_q;
            idx_d    = 2'h0;
            pend_d   = 1'b0;
          end else if (idx_q == 2'h3) begin
            seq_d = MSC_SQ_IDLE;
          end else begin
            tx_start = 1'b1;
            idx_d    = idx_q + 2'h1;
          end
        end
      end
    endcase
    if (rd_pop) begin
      pend_d = 1'b1;
      pblk_d = bo_code[1:0];
    end
    lat_d = pend_q ? lat_q + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      seq_q  <= MSC_SQ_IDLE;
      div_q  <= `MSC_DIV_RST;
      blk_q  <= 2'h0;
      idx_q  <= 2'h0;
      pblk_q <= 2'h0;
      pend_q <= 1'b0;
      lat_q  <= 16'h0000;
    end else begin
      seq_q  <= seq_d;
      div_q  <= div_d;
      blk_q  <= blk_d;
      idx_q  <= idx_d;
      pblk_q <= pblk_d;
      pend_q <= pend_d;
      lat_q  <= lat_d;
    end
  end
  // Address of the register going out with this start
  assign reg_addr        = {blk_d, idx_d};
  assign reg_flags_clear = tx_start;
  msc_up_tx u_tx (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .link_tick (link_rise),
    .div_sel   (div_q),
    .start     (tx_start),
    .addr      ({blk_d, idx_d}),
    .data      (reg_data),
    .up_out    (upstream_out),
    .up_oe     (upstream_oe),
    .busy      (),
    .done      (tx_done)
  );

  // ==========================================================
  // Checks
  AST_DIV_RESET: assert property (@(posedge core_clk)
    !rst_n |=> (div_q == 2'h2))
    else $error("divider not 64 after reset");
  AST_LEN_ERR: assert property (@(posedge core_clk) disable iff (!rst_n)
    bad_len |=> frame_length_error_flag)
    else $error("length error not flagged");
  AST_REJECT_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    bad_len |=> ($stable(w1_q) && $stable(w4_q) && !control_update
                 && !$rose(stg_q)))
    else $error("rejected frame changed outputs");
  AST_DATA_APPLY: assert property (@(posedge core_clk) disable iff (!rst_n)
    good_dat |=> (control_update
                  && (control_word_four == $past(shift_q[30:25]))))
    else $error("valid data frame not applied");
  AST_EXEC_TIME: assert property (@(posedge core_clk) disable iff (!rst_n)
    good_cmd |=> ##[0:EXEC_CYC] (stg_q && buf_in_ready))
    else $error("command not executed in time");
  AST_IGNORE_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!sel_act && !sel_fall) |=> $stable(cnt_q))
    else $error("bits counted while deselected");
  AST_READ_LAT: assert property (@(posedge core_clk) disable iff (!rst_n)
    pend_q |-> (lat_q < 16'(READ_LIMIT_CYC)))
    else $error("read answer started too late");
  AST_READ_FOUR: assert property (@(posedge core_clk) disable iff (!rst_n)
    (tx_done && !pend_q && idx_q != 2'h3) |-> tx_start)
    else $error("read sequence cut short");
  COV_DATA: cover property (@(posedge core_clk) disable iff (!rst_n)
    good_dat);
  COV_READ: cover property (@(posedge core_clk) disable iff (!rst_n)
    rd_pop ##[1:1000] tx_start);
  COV_LEN: cover property (@(posedge core_clk) disable iff (!rst_n)
    bad_len);
  COV_RESTART: cover property (@(posedge core_clk) disable iff (!rst_n)
    tx_done && pend_q && seq_q == MSC_SQ_BUSY);

endmodule // msc_slave

// [bench/msc_host.sv]
// Purpose: Host model, link clock and downstream frames
// Assumes: Link clock is core_clk/8, 25 MHz
// Notes:   Data line toggles while select is inactive
`timescale 1ns/1ps
module msc_host (
  input  wire logic core_clk,
  output logic      link_clock_pos,
  output logic      link_clock_neg,
  output logic      downstream_data_pos,
  output logic      downstream_data_neg,
  output logic      select_n
);
  logic [2:0] ph_q    = 3'h0;
  logic       sel_q   = 1'b1;
  logic       dat_q   = 1'b0;
  logic       busy_q  = 1'b0;
  logic       noise_q = 1'b0;

  // ==========================================================
  // Free-running link clock
  always @(posedge core_clk) begin
    ph_q    <= ph_q + 3'h1;
    noise_q <= ~noise_q;
  end
  assign link_clock_pos      = ~ph_q[2];
  assign link_clock_neg      = ph_q[2];
  assign downstream_data_pos = busy_q ? dat_q : noise_q;
  assign downstream_data_neg = ~downstream_data_pos;
  assign select_n            = sel_q;

  // ==========================================================
  // Frame sender
  task automatic rise();
    do @(posedge core_clk); while (ph_q != 3'h7);
  endtask

  task automatic send(input logic [31:0] bits, input int n);
    rise();
    sel_q  <= 1'b0;
    busy_q <= 1'b1;
    dat_q  <= bits[0];
    for (int i = 1; i < n; i++) begin
      rise();
      dat_q <= bits[i];
    end
    rise();
    sel_q  <= 1'b1;
    busy_q <= 1'b0;
    rise();
    rise();
  endtask
endmodule // msc_host

// [bench/msc_slave_test.sv]
// Purpose: Self-checking bench of the serial channel slave port
// Assumes: Upstream pin has a pull-up
// Notes:   Register data comes from a random table
`timescale 1ns/1ps
module msc_slave_test;
  import msc_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       cmd_ready = 1'b0;
  logic       length_error_clear = 1'b0;
  logic       lk_p, lk_n, dd_p, dd_n, sel_n, up_out, up_oe;
  logic       cmd_valid, upd, len_err, flags_clr;
  msc_code_t  cmd_code;
  msc_byte_t  cmd_arg, cw1, cw2, cw3, reg_data;
  logic [5:0] cw4;
  msc_addr_t  reg_addr, start_addr;
  msc_byte_t  lut [16];
  int         sel [4] = '{2, 0, 1, 3};
  int         mismatches = 0;
  int         total_checks = 0;
  int         cyc = 0, since_rise = 0, upd_cnt = 0, upd_lat = 0;
  int         start_cnt = 0, start_time = 0, seen = 0, prev_time = 0;

  always #2.5 core_clk = ~core_clk;
  assign reg_data = lut[reg_addr];

  msc_host u_msc_host (.core_clk(core_clk), .link_clock_pos(lk_p),
    .link_clock_neg(lk_n), .downstream_data_pos(dd_p),
    .downstream_data_neg(dd_n), .select_n(sel_n));

  msc_slave u_msc_slave (.core_clk(core_clk), .rst_n(rst_n),
    .link_clock_pos(lk_p), .link_clock_neg(lk_n),
    .downstream_data_pos(dd_p), .downstream_data_neg(dd_n),
    .select_n(sel_n), .upstream_out(up_out), .upstream_oe(up_oe),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_code(cmd_code),
    .cmd_arg(cmd_arg), .control_word_one(cw1), .control_word_two(cw2),
    .control_word_three(cw3), .control_word_four(cw4),
    .control_update(upd), .frame_length_error_flag(len_err),
    .length_error_clear(length_error_clear), .reg_addr(reg_addr),
    .reg_data(reg_data), .reg_flags_clear(flags_clr));

  // ==========================================================
  // Monitors and timeout
  always @(posedge core_clk) begin
    cyc        <= cyc + 1;
    since_rise <= sel_n ? since_rise + 1 : 0;
    if (upd === 1'b1) begin
      upd_cnt <= upd_cnt + 1;
      upd_lat <= since_rise;
    end
    if (flags_clr === 1'b1) begin
      start_cnt  <= start_cnt + 1;
      start_addr <= reg_addr;
      start_time <= cyc;
    end
    if (cyc >= 90000) begin
      mismatches = mismatches + 1;
      end_of_test();
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    seen = start_cnt;
  endtask

  task automatic clr_err();
    @(posedge core_clk);
    length_error_clear <= 1'b1;
    @(posedge core_clk);
    length_error_clear <= 1'b0;
    @(negedge core_clk);
    chk(len_err, 0);
  endtask

  task automatic data_frame(input logic [29:0] w, input int n);
    logic [29:0] old;
    int          c0;
    old = {cw4, cw3, cw2, cw1};
    c0  = upd_cnt;
    u_msc_host.send({1'b0, w, 1'b0}, n);
    repeat (128) @(negedge core_clk);
    chk(upd_cnt - c0, n == 31);
    if (n == 31) chk(upd_lat <= 128, 1);
    chk({cw4, cw3, cw2, cw1}, n == 31 ? w : old);
    chk(len_err, n != 31);
    if (n != 31) clr_err();
  endtask

  task automatic cmd_frames(input int k, input int n);
    logic [13:0] q [$];
    logic [13:0] v;
    for (int i = 0; i < k; i++) begin
      v = {8'($urandom), 6'($urandom_range(2, 31))};
      q.push_back(v);
      u_msc_host.send({17'h0, v, 1'b1}, n);
    end
    repeat (40) @(negedge core_clk);
    chk(len_err, n != 15);
    if (n != 15) begin
      chk(cmd_valid, 0);
      clr_err();
    end
    else begin
      foreach (q[i]) begin
        chk({cmd_valid, cmd_arg, cmd_code}, {1'b1, q[i]});
        @(posedge core_clk);
        cmd_ready <= 1'b1;
        @(posedge core_clk);
        cmd_ready <= 1'b0;
        @(negedge core_clk);
      end
      chk(cmd_valid, 0);
    end
  endtask

  task automatic recv(input msc_addr_t ea, input int bt, input bit chain);
    logic [15:0] f, e;
    int          d;
    for (int i = 0; i < 20000 && start_cnt == seen; i++) @(negedge core_clk);
    chk(start_cnt - seen, 1);
    seen = seen + 1;
    chk(start_addr, ea);
    d = start_time - prev_time;
    if (chain) chk(d >= 17 * bt - 8 && d <= 17 * bt + 8, 1);
    prev_time = start_time;
    e = {3'b110, lut[ea], ea, 1'b0};
    e[13] = ~^e;
    for (int k = 0; k < 17; k++) begin
      while (cyc < start_time + 1 + bt / 2 + k * bt) @(negedge core_clk);
      if (k < 16) f[k] = up_oe ? up_out : 1'b1;
    end
    chk(f, e);
    chk(up_oe, 0);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [1:0] b;
    void'($urandom(40610));
    foreach (lut[i]) lut[i] = 8'($urandom);
    do_reset();
    for (int i = 0; i < 4; i++) data_frame(30'($urandom), 31);
    data_frame(30'($urandom), 30);
    data_frame(30'($urandom), 32);
    $display("test data frames done");
    cmd_frames(3, 15);
    cmd_frames(1, 14);
    cmd_frames(1, 16);
    $display("test command frames done");
    foreach (sel[i]) begin
      do_reset();
      if (sel[i] != 2) u_msc_host.send({17'h0, 8'(sel[i]), 7'h03}, 15);
      b = 2'($urandom);
      u_msc_host.send({17'h0, 8'h00, 4'h8, b, 1'b1}, 15);
      recv({b, 2'h0}, (16 << sel[i]) * 8, 0);
      $display("test upstream ratio %0d done", 16 << sel[i]);
    end
    do_reset();
    u_msc_host.send({17'h0, 8'h00, 7'h03}, 15);
    u_msc_host.send({17'h0, 8'h00, 7'h45}, 15);
    recv(4'h8, 128, 0);
    fork
      recv(4'h9, 128, 1);
      u_msc_host.send({17'h0, 8'h00, 7'h47}, 15);
    join
    for (int i = 0; i < 4; i++) recv({2'h3, 2'(i)}, 128, 1);
    repeat (3000) @(negedge core_clk);
    chk(start_cnt, seen);
    $display("test read sequence done");
    end_of_test();
  end
endmodule // msc_slave_test
